// *** logic/pc_stack_pkg.sv ***
// Package for the program counter and return stack unit.
// Assumes a single clock domain and a plain register port.
package pc_stack_pkg;

    localparam int          PC_W          = 21;
    localparam int          SP_W          = 5;
    localparam int          STACK_DEPTH   = 31;
    localparam logic [4:0]  SP_MAX        = 5'h1f;
    localparam logic [20:0] PC_RESET      = 21'h000000;
    localparam logic [20:0] PC_STEP       = 21'h000002;

    // Register offsets (byte addresses on the register port)
    localparam logic [3:0]  ADDR_PC_LOW   = 4'h0;
    localparam logic [3:0]  ADDR_PC_HLAT  = 4'h1;
    localparam logic [3:0]  ADDR_PC_ULAT  = 4'h2;
    localparam logic [3:0]  ADDR_SP       = 4'h3;
    localparam logic [3:0]  ADDR_TOS_LOW  = 4'h4;
    localparam logic [3:0]  ADDR_TOS_HIGH = 4'h5;
    localparam logic [3:0]  ADDR_TOS_UP   = 4'h6;
    localparam logic [3:0]  ADDR_CONFIG   = 4'h7;

    // Pointer register fields
    localparam int          SP_FULL_BIT   = 7;
    localparam int          SP_UNF_BIT    = 6;
    localparam logic [7:0]  SP_RESET      = 8'h00;

    // Config register fields
    localparam int          CFG_FAULT_BIT = 0;
    localparam int          CFG_EXT_BIT   = 1;
    localparam int          CFG_SHIFT_BIT = 3;
    localparam logic [7:0]  CFG_RESET     = 8'h01;

    localparam logic [20:0] ONCHIP_SIZE   = 21'h020000;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_FETCH,
        OP_CALL,
        OP_JUMP,
        OP_RETURN,
        OP_IRQ_ACK,
        OP_SW_PUSH,
        OP_SW_POP,
        OP_LINK_RET
    } pc_op_t;

    typedef struct packed {
        pc_op_t      op;
        logic        fast;
        logic [20:0] target;
    } pc_cmd_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] work;
        logic [7:0] bank;
    } shadow_t;

endpackage

// *** logic/program_counter_return_stack.sv ***
// Program counter, return stack and fast shadow stack of the core.
// Assumes decode issues one command per cycle and no register
// access to the counter low byte in the same cycle as a command.
//
// Summary of operation
// - Program counter is 21 bits across low, high and upper bytes.
// - Low byte read/write; high and upper bytes only via latches.
// - Writing low byte loads high and upper from their latches.
// - Reading low byte copies high and upper into the latches.
// - Bit 0 is always zero; sequential fetch adds two.
// - Calls, jumps and branches load counter directly, latches unused.
// - Return stack is 31 by 21 bits with a 5-bit pointer.
// - Push on call/irq; pop on returns and linked ops; latches untouched.
// - Push increments pointer, then writes counter at new top.
// - Pop loads top into counter, then decrements pointer.
// - Reset clears pointer; pointer zero has no storage.
// - Top-of-stack registers access the entry at the pointer.
// - Full flag sets after 31 pushes; cleared only by software or reset.
// - Fault reset on: 31st push stores counter, flags, resets, pointer zero.
// - Fault reset off: pointer stays 31, further pushes ignored.
// - Empty pop loads zero, sets underflow flag, pointer stays zero.
// - Fault reset on: full or underflow resets device; else flag only.
// - Pointer register: full bit 7, underflow bit 6, bit 5 zero, ptr 4:0.
// - Software push stores counter; software pop only decrements pointer.
// - Interrupt vectoring saves shadow; fast interrupt return restores it.
// - Fast call saves shadow; fast return restores it.
// - Extended mode with shifting subtracts on-chip size from external address.
// - Shift enable bit 3 selects shifting; zero gives raw counter.
`timescale 1ns/1ns
`default_nettype none

module program_counter_return_stack
    import pc_stack_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire pc_cmd_t     cmd,
    input  wire shadow_t     regs_in,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    output logic [20:0]      pc_out,
    output logic [20:0]      ext_addr,
    output logic             ext_select,
    output shadow_t          shadow_out,
    output logic             shadow_restore,
    output logic             stack_reset_req
);

    logic [20:0] pc_ff;
    logic [7:0]  pc_high_latch_ff;
    logic [4:0]  pc_upper_latch_ff;
    logic [4:0]  sp_ff;
    logic        stack_full_flag_ff;
    logic        stack_underflow_flag_ff;
    logic [7:0]  cfg_ff;
    logic [20:0] stack_mem [1:STACK_DEPTH];
    shadow_t     shadow_ff;
    logic        shadow_restore_ff;
    logic        reset_req_ff;
    logic [7:0]  rdata_ff;
    logic [20:0] ext_addr_ff;
    logic        ext_select_ff;

    logic        fault_en;
    logic        is_push;
    logic        is_pop;
    logic        push_blocked;
    logic        push_last;
    logic        pop_empty;
    logic [20:0] push_val;
    logic [20:0] tos_val;
    logic [20:0] nxt_pc;
    logic [4:0]  nxt_sp;
    logic [20:0] nxt_ext;
    logic        full_set;
    logic        shadow_save;
    logic        push_we;
    logic [4:0]  push_idx;

    // Register port decodes
    logic        wr_pc_low;
    logic        wr_hlat;
    logic        wr_ulat;
    logic        wr_ptr;
    logic        wr_cfg;
    logic        wr_tos;
    logic        rd_pc_low;

    function automatic logic [20:0] align(input logic [20:0] a);
        align = {a[20:1], 1'b0};
    endfunction

    // One decode shared by the counter, latch, pointer and config writes and the counter low byte read
    function automatic logic hit(input logic       strobe,
                                 input logic [3:0] addr,
                                 input logic [3:0] want);
        hit = strobe && (addr == want);
    endfunction

    assign fault_en     = cfg_ff[CFG_FAULT_BIT];

    assign wr_pc_low    = hit(reg_wr, reg_addr, ADDR_PC_LOW);
    assign wr_hlat      = hit(reg_wr, reg_addr, ADDR_PC_HLAT);
    assign wr_ulat      = hit(reg_wr, reg_addr, ADDR_PC_ULAT);
    assign wr_ptr       = hit(reg_wr, reg_addr, ADDR_SP);
    assign wr_cfg       = hit(reg_wr, reg_addr, ADDR_CONFIG);
    // Entry zero has no storage, so a top-of-stack write there is dropped
    assign wr_tos       = reg_wr && (sp_ff != 5'h00);
    assign rd_pc_low    = hit(reg_rd, reg_addr, ADDR_PC_LOW);

    // A push at the top also marks full, even when it is refused
    assign full_set     = push_last || (is_push && sp_ff == SP_MAX);
    assign shadow_save  = (cmd.op == OP_IRQ_ACK)
                          || (cmd.op == OP_CALL && cmd.fast);
    assign push_we      = is_push && !push_blocked;
    assign push_idx     = sp_ff + 5'h01;
    assign is_push      = (cmd.op == OP_CALL) || (cmd.op == OP_IRQ_ACK)
                          || (cmd.op == OP_SW_PUSH);
    assign is_pop       = (cmd.op == OP_RETURN) || (cmd.op == OP_LINK_RET)
                          || (cmd.op == OP_SW_POP);
    assign push_blocked = is_push && (sp_ff == SP_MAX) && !fault_en;
    assign push_last    = is_push && (sp_ff == SP_MAX - 5'h01);
    assign pop_empty    = is_pop && (sp_ff == 5'h00);
    assign tos_val      = (sp_ff == 5'h00) ? PC_RESET : stack_mem[sp_ff];
    // Counter already points past the call; on the final trapping push
    // the stored value is the counter itself as for any other push.
    assign push_val     = align(pc_ff);

    // Counter next value
    always_comb begin
        nxt_pc = pc_ff;
        case (cmd.op)
            OP_FETCH:    nxt_pc = align(pc_ff + PC_STEP);
            OP_CALL,
            OP_JUMP,
            OP_IRQ_ACK:  nxt_pc = align(cmd.target);
            OP_RETURN,
            OP_LINK_RET: nxt_pc = pop_empty ? PC_RESET : align(tos_val);
            OP_SW_POP:   nxt_pc = pop_empty ? PC_RESET : pc_ff;
            default:     nxt_pc = pc_ff;
        endcase
        // Software write wins over any command in the same cycle; a fault reset wins over both
        if (wr_pc_low) begin
            nxt_pc = {pc_upper_latch_ff, pc_high_latch_ff,
                      reg_wdata[7:1], 1'b0};
        end
        if ((push_last || pop_empty) && fault_en) begin
            nxt_pc = PC_RESET;
        end
    end

    // Pointer next value
    always_comb begin
        nxt_sp = sp_ff;
        if (wr_ptr) begin
            nxt_sp = reg_wdata[4:0];
        end else if (is_push && !push_blocked) begin
            nxt_sp = sp_ff + 5'h01;
        end else if (is_pop && !pop_empty) begin
            nxt_sp = sp_ff - 5'h01;
        end
        if ((push_last || pop_empty) && fault_en) begin
            nxt_sp = 5'h00;
        end
    end

    // External bus address with optional shift
    always_comb begin
        nxt_ext = nxt_pc;
        if (cfg_ff[CFG_EXT_BIT] && cfg_ff[CFG_SHIFT_BIT] && nxt_pc >= ONCHIP_SIZE) begin
            nxt_ext = nxt_pc - ONCHIP_SIZE;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pc_ff <= PC_RESET;
        end else begin
            pc_ff <= nxt_pc;
        end
    end

    // High latch: written by software, refreshed by a low byte read
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pc_high_latch_ff <= 8'h00;
        end else if (rd_pc_low) begin
            pc_high_latch_ff <= pc_ff[15:8];
        end else if (wr_hlat) begin
            pc_high_latch_ff <= reg_wdata;
        end
    end

    // Upper latch: same scheme, five bits only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pc_upper_latch_ff <= 5'h00;
        end else if (rd_pc_low) begin
            pc_upper_latch_ff <= pc_ff[20:16];
        end else if (wr_ulat) begin
            pc_upper_latch_ff <= reg_wdata[4:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sp_ff <= 5'h00;
        end else begin
            sp_ff <= nxt_sp;
        end
    end

    // Full flag: hardware set wins over a software clear in one cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stack_full_flag_ff <= 1'b0;
        end else if (full_set) begin
            stack_full_flag_ff <= 1'b1;
        end else if (wr_ptr && !reg_wdata[SP_FULL_BIT]) begin
            stack_full_flag_ff <= 1'b0;
        end
    end

    // Underflow flag: writing one leaves it, writing zero clears it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stack_underflow_flag_ff <= 1'b0;
        end else if (pop_empty) begin
            stack_underflow_flag_ff <= 1'b1;
        end else if (wr_ptr && !reg_wdata[SP_UNF_BIT]) begin
            stack_underflow_flag_ff <= 1'b0;
        end
    end

    // Stack storage has no reset; entry zero does not exist
    always_ff @(posedge clk) begin
        if (push_we) begin
            stack_mem[push_idx] <= push_val;
        end else if (wr_tos) begin
            case (reg_addr)
                ADDR_TOS_LOW:  stack_mem[sp_ff][7:0]   <= {reg_wdata[7:1], 1'b0};
                ADDR_TOS_HIGH: stack_mem[sp_ff][15:8]  <= reg_wdata;
                ADDR_TOS_UP:   stack_mem[sp_ff][20:16] <= reg_wdata[4:0];
                default:       ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_ff <= CFG_RESET;
        end else if (wr_cfg) begin
            cfg_ff <= reg_wdata & 8'h0b;
        end
    end

    // Shadow stack, one level, not visible to software
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shadow_ff <= '0;
        end else if (shadow_save) begin
            shadow_ff <= regs_in;
        end
    end

    // Strobe only; the core copies the saved values back itself.
    // A nested interrupt overwrites the single level, by design.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shadow_restore_ff <= 1'b0;
        end else begin
            shadow_restore_ff <= (cmd.op == OP_RETURN) && cmd.fast;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reset_req_ff <= 1'b0;
        end else begin
            reset_req_ff <= fault_en && (push_last || pop_empty);
        end
    end

    // Register read port, data one cycle after the strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_PC_LOW:   rdata_ff <= pc_ff[7:0];
                ADDR_PC_HLAT:  rdata_ff <= pc_high_latch_ff;
                ADDR_PC_ULAT:  rdata_ff <= {3'b000, pc_upper_latch_ff};
                ADDR_SP:       rdata_ff <= {stack_full_flag_ff, stack_underflow_flag_ff,
                                            1'b0, sp_ff};
                ADDR_TOS_LOW:  rdata_ff <= tos_val[7:0];
                ADDR_TOS_HIGH: rdata_ff <= tos_val[15:8];
                ADDR_TOS_UP:   rdata_ff <= {3'b000, tos_val[20:16]};
                ADDR_CONFIG:   rdata_ff <= cfg_ff;
                default:       rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    // Built from the next counter so the bus tracks pc_out in step
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ext_addr_ff <= PC_RESET;
        end else begin
            ext_addr_ff <= nxt_ext;
        end
    end

    // External memory selected only above the on-chip space
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ext_select_ff <= 1'b0;
        end else begin
            ext_select_ff <= cfg_ff[CFG_EXT_BIT] && (nxt_pc >= ONCHIP_SIZE);
        end
    end

    assign reg_rdata       = rdata_ff;
    assign pc_out          = pc_ff;
    assign ext_addr        = ext_addr_ff;
    assign ext_select      = ext_select_ff;
    assign shadow_out      = shadow_ff;
    assign shadow_restore  = shadow_restore_ff;
    assign stack_reset_req = reset_req_ff;

endmodule

`default_nettype wire

// *** testbench/pcrs_decoder.sv ***
// Decoder-side model: issues one command per call, idle otherwise.
// Assumes the bench calls issue from its main thread only.
`timescale 1ns/1ns
`default_nettype none
module pcrs_decoder
    import pc_stack_pkg::*;
(
    input  wire logic clk,
    output pc_cmd_t   cmd,
    output shadow_t   regs
);
    initial begin
        cmd = '0;
        regs = 24'h0a0b0c;
    end
    // Live registers move every cycle, so a late capture shows
    always @(posedge clk) begin
        regs <= regs + 24'h010203;
    end
    task automatic issue(input pc_op_t op, input logic f, input logic [20:0] t);
        @(posedge clk);
        cmd <= '{op, f, t};
        @(posedge clk);
        cmd.op <= OP_NONE;
        #1;
    endtask
endmodule
`default_nettype wire

// *** testbench/pcrs_chk.sv ***
// Port checker for the counter and return stack unit.
// Assumes one clock domain; attached by bind below.
`timescale 1ns/1ns
`default_nettype none
module pcrs_chk
    import pc_stack_pkg::*;
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire pc_cmd_t     cmd,
    input wire shadow_t     regs_in,
    input wire logic [3:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic [20:0] pc_out,
    input wire logic [20:0] ext_addr,
    input wire logic        ext_select,
    input wire shadow_t     shadow_out,
    input wire logic        shadow_restore,
    input wire logic        stack_reset_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_pc_even: assert property (pc_out[0] == 1'b0)
        else $error("pc bit 0 set");
    a_fetch_step: assert property (cmd.op == OP_FETCH && !reg_wr
        |=> pc_out == $past(pc_out) + PC_STEP) else $error("fetch step wrong");
    a_jump_load: assert property (cmd.op == OP_JUMP && !reg_wr
        |=> pc_out == ($past(cmd.target) & 21'h1ffffe)) else $error("jump target wrong");
    a_pc_write: assert property (reg_wr && reg_addr == ADDR_PC_LOW
        |=> pc_out[7:0] == ($past(reg_wdata) & 8'hfe)) else $error("pc low write wrong");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read");
    a_req_pulse: assert property (stack_reset_req |=> !stack_reset_req)
        else $error("reset request too long");
    a_req_pc_zero: assert property (stack_reset_req |-> pc_out == PC_RESET)
        else $error("pc not zero on fault");
    a_shadow_save: assert property (cmd.op == OP_IRQ_ACK || cmd.op == OP_CALL && cmd.fast
        |=> shadow_out == $past(regs_in)) else $error("shadow not captured");
    a_restore_on: assert property (cmd.op == OP_RETURN && cmd.fast |=> shadow_restore)
        else $error("no restore pulse");
    a_restore_only: assert property (!(cmd.op == OP_RETURN && cmd.fast)
        |=> !shadow_restore) else $error("stray restore pulse");
    a_ext_map: assert property (ext_addr == pc_out
        || ext_select && ext_addr == pc_out - ONCHIP_SIZE) else $error("ext address wrong");
endmodule
bind program_counter_return_stack pcrs_chk u_chk (.clk(clk), .resetn(resetn), .cmd(cmd),
    .regs_in(regs_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pc_out(pc_out), .ext_addr(ext_addr),
    .ext_select(ext_select), .shadow_out(shadow_out), .shadow_restore(shadow_restore),
    .stack_reset_req(stack_reset_req));
`default_nettype wire

// *** testbench/program_counter_return_stack_tb.sv ***
// Bench for the counter and return stack: register and command sequences.
// Assumes the decoder model drives cmd and the live registers.
`timescale 1ns/1ns
`default_nettype none
module program_counter_return_stack_tb
    import pc_stack_pkg::*;
;
    logic        clk;
    logic        resetn;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [20:0] pc_out;
    logic [20:0] ext_addr;
    logic        ext_select;
    logic        shadow_restore;
    logic        stack_reset_req;
    pc_cmd_t     cmd;
    shadow_t     regs_in;
    shadow_t     shadow_out;
    int          err_count;
    int          n_checks;
    logic [7:0]  d;
    program_counter_return_stack u_dut (.clk(clk), .resetn(resetn), .cmd(cmd),
        .regs_in(regs_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pc_out(pc_out), .ext_addr(ext_addr),
        .ext_select(ext_select), .shadow_out(shadow_out), .shadow_restore(shadow_restore),
        .stack_reset_req(stack_reset_req));
    pcrs_decoder u_dec (.clk(clk), .cmd(cmd), .regs(regs_in));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        resetn = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        err_count = 0;
        n_checks = 0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        rd(ADDR_SP);
        chk("sp_reset", d, SP_RESET);
        rd(ADDR_CONFIG);
        chk("cfg_reset", d, CFG_RESET);
        repeat (2) u_dec.issue(OP_FETCH, 1'b0, 21'h0);
        chk("fetch", pc_out, 21'h000004);
        u_dec.issue(OP_CALL, 1'b0, 21'h000123);
        chk("call_pc", pc_out, 21'h000122);
        rd(ADDR_SP);
        chk("sp_call", d, 8'h01);
        rd(ADDR_TOS_LOW);
        chk("tos_low", d, 8'h04);
        rd(ADDR_PC_LOW);
        chk("pc_low", d, 8'h22);
        rd(ADDR_PC_HLAT);
        chk("latch_copy", d, 8'h01);
        wr(ADDR_PC_HLAT, 8'h34);
        wr(ADDR_PC_ULAT, 8'h01);
        wr(ADDR_PC_LOW, 8'h57);
        #1 chk("pc_load", pc_out, 21'h013456);
        wr(ADDR_TOS_LOW, 8'h40);
        u_dec.issue(OP_RETURN, 1'b0, 21'h0);
        chk("ret_pc", pc_out, 21'h000040);
        rd(ADDR_SP);
        chk("sp_ret", d, 8'h00);
        u_dec.issue(OP_RETURN, 1'b0, 21'h0);
        chk("unf_req", stack_reset_req, 1'b1);
        rd(ADDR_SP);
        chk("unf_flag", d, 8'h40);
        wr(ADDR_SP, 8'h00);
        wr(ADDR_CONFIG, 8'h00);
        repeat (32) u_dec.issue(OP_SW_PUSH, 1'b0, 21'h0);
        rd(ADDR_SP);
        chk("full_hold", d, 8'h9f);
        u_dec.issue(OP_JUMP, 1'b0, 21'h000200);
        u_dec.issue(OP_SW_POP, 1'b0, 21'h0);
        chk("pop_pc", pc_out, 21'h000200);
        rd(ADDR_SP);
        chk("sw_pop", d, 8'h9e);
        wr(ADDR_SP, 8'h05);
        u_dec.issue(OP_SW_POP, 1'b0, 21'h0);
        rd(ADDR_SP);
        chk("sp_write", d, 8'h04);
        wr(ADDR_SP, 8'h00);
        wr(ADDR_CONFIG, 8'h01);
        repeat (31) u_dec.issue(OP_SW_PUSH, 1'b0, 21'h0);
        chk("full_req", stack_reset_req, 1'b1);
        rd(ADDR_SP);
        chk("full_flag", d, 8'h80);
        u_dec.issue(OP_IRQ_ACK, 1'b0, 21'h000008);
        chk("irq_pc", pc_out, 21'h000008);
        u_dec.issue(OP_RETURN, 1'b1, 21'h0);
        chk("restore", shadow_restore, 1'b1);
        u_dec.issue(OP_CALL, 1'b1, 21'h000100);
        // Live registers stepped once since the capture edge
        chk("shadow", shadow_out, regs_in - 24'h010203);
        u_dec.issue(OP_RETURN, 1'b1, 21'h0);
        chk("fast_ret", pc_out, 21'h000000);
        wr(ADDR_CONFIG, 8'h0a);
        u_dec.issue(OP_JUMP, 1'b0, 21'h020011);
        chk("ext_shift", ext_addr, 21'h000010);
        chk("ext_sel", ext_select, 1'b1);
        wr(ADDR_CONFIG, 8'h02);
        rd(ADDR_CONFIG);
        chk("cfg_rd", d, 8'h02);
        chk("ext_raw", ext_addr, 21'h020010);
        rd(4'hf);
        chk("unmapped", d, 8'h00);
        conclude();
    end
endmodule
`default_nettype wire
